// ### adc_pkg.sv
package adc_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  reg_addr_t;
  typedef logic [7:0]  axi_addr_t;

  // Group register indices on the link
  localparam reg_addr_t ADR_GROUP_ANALOG_CONFIG      = 4'h0;
  localparam reg_addr_t ADR_GROUP_ARBITRATION_CONFIG = 4'h1;
  localparam reg_addr_t ADR_GLOBAL_CONFIG            = 4'h2;
  localparam reg_addr_t ADR_ARBITRATION_PRIORITY     = 4'h3;
  localparam reg_addr_t ADR_QUEUE_MODE_0             = 4'h4;
  localparam reg_addr_t ADR_INPUT_CLASS_0            = 4'h5;
  localparam reg_addr_t ADR_RESULT_CONTROL_0         = 4'h6;
  localparam reg_addr_t ADR_QUEUE_INPUT_0            = 4'h7;
  localparam reg_addr_t ADR_RESULT_REG_0             = 4'h8;

  // Initialization values
  localparam word_t INIT_ANALOG_CONFIG = 32'h0030_0000;
  localparam word_t INIT_ARBITRATION   = 32'h0000_0003;
  localparam word_t INIT_GLOBAL_CAL    = 32'h8000_0000;
  localparam word_t INIT_ARB_PRIORITY  = 32'h0100_0000;
  localparam word_t INIT_QUEUE_MODE    = 32'h0000_0001;
  localparam word_t INIT_INPUT_CLASS   = 32'h0000_0207;
  localparam word_t INIT_RESULT_CTRL   = 32'h8000_0000;
  localparam word_t INIT_QUEUE_INPUT   = 32'h0000_0020;

  // Field positions
  localparam int DIV_LSB      = 20;
  localparam int ANALOG_ON_W  = 2;
  localparam int CAL_FLAG_BIT = 28;
  localparam int CAL_START_BIT = 31;
  localparam int SLOT0_BIT    = 24;
  localparam int QUEUE_EN_BIT = 0;
  localparam int STC_W        = 5;
  localparam int PRE_LSB      = 8;
  localparam int SRQ_EN_BIT   = 31;
  localparam int REFILL_BIT   = 5;
  localparam int CH_W         = 5;
  localparam int RES_W        = 12;
  localparam int RES_CH_LSB   = 16;
  localparam int RES_VALID_BIT = 31;

  // Timing
  localparam int CLK_NS        = 100;
  localparam int WAKEUP_NS     = 5000;
  localparam int WAKEUP_CYC    = (WAKEUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STC_BASE      = 2;
  localparam int PRE_SHORT     = 8;
  localparam int PRE_MID       = 16;
  localparam int PRE_LONG      = 32;
  localparam int BUS_READ_CYC  = 5;
  localparam int UPD_BUS_CYC   = 6;
  localparam int UPD_CONV_CYC  = 6;
  localparam int UPD_CYC       = UPD_BUS_CYC + UPD_CONV_CYC;
  localparam int GAP_BUS_CYC   = 1;
  localparam int GAP_CONV_CYC  = 6;
  localparam int GAP_CYC       = GAP_BUS_CYC + GAP_CONV_CYC;

  // Controller registers on AXI4-Lite
  localparam axi_addr_t AXI_CTRL       = 8'h00;
  localparam axi_addr_t AXI_STATUS     = 8'h04;
  localparam axi_addr_t AXI_RESULT     = 8'h08;
  localparam axi_addr_t AXI_IRQ_STATUS = 8'h10;
  localparam axi_addr_t AXI_IRQ_CLEAR  = 8'h14;
  localparam axi_addr_t AXI_IRQ_ENABLE = 8'h18;
  localparam int EV_W         = 3;
  localparam int EV_INIT_DONE = 0;
  localparam int EV_RESULT    = 1;
  localparam int EV_DRAINED   = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### adc_link.sv
`timescale 1ns/10ps
interface adc_link;
  import adc_pkg::*;
  logic      wr_stb;
  logic      rd_stb;
  reg_addr_t addr;
  word_t     wdata;
  word_t     rdata;
  logic      rvalid;
  logic      srq;

  modport group
  (
    input  wr_stb, rd_stb, addr, wdata,
    output rdata, rvalid, srq
  );
  modport ctrl
  (
    output wr_stb, rd_stb, addr, wdata,
    input  rdata, rvalid, srq
  );
endinterface

// ### rate_divider.sv
`timescale 1ns/10ps
module rate_divider #(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_s;
  div_s s;
  div_s next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= div - W'(1))
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + W'(1);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
endmodule

// ### adc_group.sv
`timescale 1ns/10ps
module adc_group
  import adc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int SEQ_LEN    = 4,
  parameter int CAL_CYC    = 2000,
  parameter int CONV_CLKS  = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  adc_link.group                 lnk,
  input  wire logic [adc_pkg::RES_W-1:0] analog_data,
  output logic                   analog_on,
  output logic                   buf_boost,
  output logic                   sample_on,
  output logic [adc_pkg::CH_W-1:0] conv_channel,
  output logic                   cal_busy
);
  import adc_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int EW = CH_W + RES_W;

  typedef enum logic [1:0] {IDLE, CAL, SAMPLE, CONV} phase_e;

  typedef struct packed {
    phase_e                         phase;
    word_t                          ancfg;
    word_t                          arbcfg;
    word_t                          arbpr;
    word_t                          qmr;
    word_t                          iclass;
    word_t                          rcr;
    word_t                          qinr;
    logic                           q_valid;
    logic                           cal_done;
    logic [15:0]                    cnt;
    logic [5:0]                     pre_cnt;
    logic [FIFO_DEPTH-1:0][EW-1:0]  mem;
    logic [PW-1:0]                  wp;
    logic [PW-1:0]                  rp;
    logic [PW:0]                    count;
    logic                           rd_busy;
    logic [2:0]                     rd_cnt;
    reg_addr_t                      rd_addr;
    logic [3:0]                     upd_cnt;
    word_t                          rdata;
    logic                           rvalid;
    logic                           srq;
    logic                           analog_on;
    logic                           buf_boost;
    logic                           sample_on;
    logic [CH_W-1:0]                channel;
    logic [RES_W-1:0]               sample_q;
    logic                           cal_busy;
  } st_s;

  st_s  s;
  st_s  next_s;
  logic tick;

  function automatic logic [5:0] pre_len(input logic [1:0] code);
    case (code)
      2'h0:    pre_len = 6'(PRE_SHORT);
      2'h1:    pre_len = 6'(PRE_MID);
      default: pre_len = 6'(PRE_LONG);
    endcase
  endfunction

  function automatic word_t reg_read(input st_s v, input reg_addr_t a);
    word_t r;
    r = '0;
    case (a)
      ADR_GROUP_ANALOG_CONFIG:      r = v.ancfg;
      ADR_GROUP_ARBITRATION_CONFIG:
      begin
        r = v.arbcfg;
        r[CAL_FLAG_BIT] = v.cal_busy;
      end
      ADR_ARBITRATION_PRIORITY:     r = v.arbpr;
      ADR_QUEUE_MODE_0:             r = v.qmr;
      ADR_INPUT_CLASS_0:            r = v.iclass;
      ADR_RESULT_CONTROL_0:         r = v.rcr;
      ADR_QUEUE_INPUT_0:            r = v.qinr;
      default:                      r = '0;
    endcase
    reg_read = r;
  endfunction

  rate_divider #(.W(3)) analog_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .div     ({1'b0, s.ancfg[DIV_LSB +: 2]} + 3'h1),
    .tick    (tick)
  );

  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;
    if (s.upd_cnt != '0)
      next_s.upd_cnt = s.upd_cnt - 4'h1;
    if (lnk.wr_stb)
    begin
      case (lnk.addr)
        ADR_GROUP_ANALOG_CONFIG:      next_s.ancfg = lnk.wdata;
        ADR_GROUP_ARBITRATION_CONFIG: next_s.arbcfg = lnk.wdata;
        ADR_GLOBAL_CONFIG:
          if (lnk.wdata[CAL_START_BIT] && s.analog_on && s.phase == IDLE)
          begin
            next_s.phase = CAL;
            next_s.cnt = '0;
            next_s.cal_busy = 1'b1;
            next_s.cal_done = 1'b0;
          end
        ADR_ARBITRATION_PRIORITY:     next_s.arbpr = lnk.wdata;
        ADR_QUEUE_MODE_0:             next_s.qmr = lnk.wdata;
        ADR_INPUT_CLASS_0:            next_s.iclass = lnk.wdata;
        ADR_RESULT_CONTROL_0:         next_s.rcr = lnk.wdata;
        ADR_QUEUE_INPUT_0:
        begin
          next_s.qinr = lnk.wdata;
          next_s.q_valid = 1'b1;
        end
        default: ;
      endcase
    end
    next_s.analog_on = (next_s.arbcfg[ANALOG_ON_W-1:0] == 2'h3);

    if (lnk.rd_stb && !s.rd_busy)
    begin
      next_s.rd_busy = 1'b1;
      next_s.rd_cnt = '0;
      next_s.rd_addr = lnk.addr;
    end
    else if (s.rd_busy)
    begin
      next_s.rd_cnt = s.rd_cnt + 3'h1;
      if (s.rd_cnt == 3'(BUS_READ_CYC - 2))
      begin
        next_s.rd_busy = 1'b0;
        next_s.rvalid = 1'b1;
        next_s.rdata = reg_read(s, s.rd_addr);
        if (s.rd_addr == ADR_RESULT_REG_0)
        begin
          next_s.rdata = '0;
          if (s.count != '0 && s.upd_cnt == '0)
          begin
            next_s.rdata[RES_VALID_BIT] = 1'b1;
            next_s.rdata[RES_CH_LSB +: CH_W] = s.mem[s.rp][EW-1:RES_W];
            next_s.rdata[RES_W-1:0] = s.mem[s.rp][RES_W-1:0];
            next_s.rp = s.rp + PW'(1);
            next_s.count = next_s.count - (PW+1)'(1);
            next_s.upd_cnt = 4'(UPD_CYC);
          end
        end
      end
    end

    case (s.phase)
      IDLE:
        if (s.cal_done && s.analog_on && s.arbpr[SLOT0_BIT]
            && s.qmr[QUEUE_EN_BIT] && s.q_valid)
        begin
          next_s.phase = SAMPLE;
          next_s.cnt = '0;
          next_s.pre_cnt = '0;
          next_s.sample_on = 1'b1;
          next_s.buf_boost = 1'b1;
          next_s.channel = s.qinr[CH_W-1:0];
        end
      CAL:
      begin
        next_s.cnt = s.cnt + 16'h1;
        if (s.cnt == 16'(CAL_CYC - 1))
        begin
          next_s.phase = IDLE;
          next_s.cal_busy = 1'b0;
          next_s.cal_done = 1'b1;
        end
      end
      SAMPLE:
      begin
        next_s.pre_cnt = s.pre_cnt + 6'h1;
        if (s.pre_cnt == pre_len(s.iclass[PRE_LSB +: 2]) - 6'h1)
          next_s.buf_boost = 1'b0;
        if (tick)
        begin
          next_s.cnt = s.cnt + 16'h1;
          if (s.cnt == 16'(s.iclass[STC_W-1:0]) + 16'(STC_BASE - 1))
          begin
            next_s.phase = CONV;
            next_s.cnt = '0;
            next_s.sample_on = 1'b0;
            next_s.buf_boost = 1'b0;
            next_s.sample_q = analog_data;
          end
        end
      end
      CONV:
      begin
        if (tick && s.cnt < 16'(CONV_CLKS))
          next_s.cnt = s.cnt + 16'h1;
        if (s.cnt >= 16'(CONV_CLKS) && s.count < (PW+1)'(FIFO_DEPTH))
        begin
          next_s.mem[s.wp] = {s.channel, s.sample_q};
          next_s.wp = s.wp + PW'(1);
          next_s.count = next_s.count + (PW+1)'(1);
          next_s.cnt = '0;
          if (s.qinr[REFILL_BIT] && s.analog_on)
          begin
            next_s.phase = SAMPLE;
            next_s.pre_cnt = '0;
            next_s.sample_on = 1'b1;
            next_s.buf_boost = 1'b1;
          end
          else
          begin
            next_s.phase = IDLE;
            next_s.q_valid = lnk.wr_stb
                             && lnk.addr == ADR_QUEUE_INPUT_0;
          end
        end
      end
      default: next_s.phase = IDLE;
    endcase
    next_s.srq = next_s.rcr[SRQ_EN_BIT]
                 && next_s.count >= (PW+1)'(SEQ_LEN);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign lnk.rdata    = s.rdata;
  assign lnk.rvalid   = s.rvalid;
  assign lnk.srq      = s.srq;
  assign analog_on    = s.analog_on;
  assign buf_boost    = s.buf_boost;
  assign sample_on    = s.sample_on;
  assign conv_channel = s.channel;
  assign cal_busy     = s.cal_busy;
endmodule

// ### adc_host.sv
`timescale 1ns/10ps
module adc_host
  import adc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  adc_link.ctrl                  lnk,
  input  wire adc_pkg::axi_addr_t awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire adc_pkg::word_t    wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire adc_pkg::axi_addr_t araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output adc_pkg::word_t         rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq
);
  import adc_pkg::*;

  typedef enum logic [2:0]
    {H_IDLE, H_WR, H_WAKE, H_POLL, H_PWAIT, H_RUN, H_RWAIT, H_GAP} hstate_e;

  typedef struct packed {
    hstate_e         st;
    logic [2:0]      step;
    logic [15:0]     cnt;
    logic            aw_hold;
    axi_addr_t       aw_q;
    logic            w_hold;
    word_t           w_q;
    logic [3:0]      strb_q;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    word_t           rdata;
    logic [1:0]      rresp;
    logic            auto_read;
    word_t           result;
    logic [EV_W-1:0] ev_sts;
    logic [EV_W-1:0] ev_en;
    logic            irq;
    logic            wr_stb;
    logic            rd_stb;
    reg_addr_t       addr;
    word_t           ldata;
  } st_s;

  st_s s;
  st_s next_s;

  function automatic reg_addr_t step_addr(input logic [2:0] i);
    case (i)
      3'h0:    step_addr = ADR_GROUP_ANALOG_CONFIG;
      3'h1:    step_addr = ADR_GROUP_ARBITRATION_CONFIG;
      3'h2:    step_addr = ADR_GLOBAL_CONFIG;
      3'h3:    step_addr = ADR_ARBITRATION_PRIORITY;
      3'h4:    step_addr = ADR_QUEUE_MODE_0;
      3'h5:    step_addr = ADR_INPUT_CLASS_0;
      3'h6:    step_addr = ADR_RESULT_CONTROL_0;
      default: step_addr = ADR_QUEUE_INPUT_0;
    endcase
  endfunction

  function automatic word_t step_data(input logic [2:0] i);
    case (i)
      3'h0:    step_data = INIT_ANALOG_CONFIG;
      3'h1:    step_data = INIT_ARBITRATION;
      3'h2:    step_data = INIT_GLOBAL_CAL;
      3'h3:    step_data = INIT_ARB_PRIORITY;
      3'h4:    step_data = INIT_QUEUE_MODE;
      3'h5:    step_data = INIT_INPUT_CLASS;
      3'h6:    step_data = INIT_RESULT_CTRL;
      default: step_data = INIT_QUEUE_INPUT;
    endcase
  endfunction

  always_comb
  begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic            start;
    ev = '0;
    clr = '0;
    start = 1'b0;
    next_s = s;
    next_s.wr_stb = 1'b0;
    next_s.rd_stb = 1'b0;

    // AXI4-Lite write path
    if (awvalid && s.awready)
    begin
      next_s.aw_hold = 1'b1;
      next_s.aw_q = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_hold = 1'b1;
      next_s.w_q = wdata;
      next_s.strb_q = wstrb;
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (s.aw_hold && s.w_hold && !s.bvalid)
    begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.aw_q)
        AXI_CTRL:
          if (s.strb_q[0])
          begin
            start = s.w_q[0];
            next_s.auto_read = s.w_q[1];
          end
        AXI_IRQ_CLEAR:  if (s.strb_q[0]) clr = s.w_q[EV_W-1:0];
        AXI_IRQ_ENABLE: if (s.strb_q[0]) next_s.ev_en = s.w_q[EV_W-1:0];
        AXI_STATUS, AXI_RESULT, AXI_IRQ_STATUS: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_hold;
    next_s.wready = !next_s.w_hold;

    // AXI4-Lite read path
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (araddr)
        AXI_CTRL:       next_s.rdata[1] = s.auto_read;
        AXI_STATUS:
        begin
          next_s.rdata[0] = (s.st != H_IDLE) && (s.st < H_RUN);
          next_s.rdata[1] = (s.st >= H_RUN);
        end
        AXI_RESULT:     next_s.rdata = s.result;
        AXI_IRQ_STATUS: next_s.rdata[EV_W-1:0] = s.ev_sts;
        AXI_IRQ_ENABLE: next_s.rdata[EV_W-1:0] = s.ev_en;
        AXI_IRQ_CLEAR:  ;
        default:        next_s.rresp = RESP_SLVERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Initialization sequence and result reader
    case (s.st)
      H_IDLE: ;
      H_WR:
      begin
        next_s.wr_stb = 1'b1;
        next_s.addr = step_addr(s.step);
        next_s.ldata = step_data(s.step);
        next_s.step = s.step + 3'h1;
        next_s.cnt = '0;
        if (s.step == 3'h1)
          next_s.st = H_WAKE;
        else if (s.step == 3'h7)
          next_s.st = H_POLL;
      end
      H_WAKE:
      begin
        next_s.cnt = s.cnt + 16'h1;
        if (s.cnt == 16'(WAKEUP_CYC - 1))
          next_s.st = H_WR;
      end
      H_POLL:
      begin
        next_s.rd_stb = 1'b1;
        next_s.addr = ADR_GROUP_ARBITRATION_CONFIG;
        next_s.st = H_PWAIT;
      end
      H_PWAIT:
        if (lnk.rvalid)
        begin
          if (!lnk.rdata[CAL_FLAG_BIT])
          begin
            ev[EV_INIT_DONE] = 1'b1;
            next_s.st = H_RUN;
          end
          else
            next_s.st = H_POLL;
        end
      H_RUN:
        if (s.auto_read && lnk.srq)
        begin
          next_s.rd_stb = 1'b1;
          next_s.addr = ADR_RESULT_REG_0;
          next_s.st = H_RWAIT;
        end
      H_RWAIT:
        if (lnk.rvalid)
        begin
          next_s.cnt = '0;
          if (lnk.rdata[RES_VALID_BIT])
          begin
            next_s.result = lnk.rdata;
            ev[EV_RESULT] = 1'b1;
            next_s.st = H_GAP;
          end
          else
          begin
            ev[EV_DRAINED] = 1'b1;
            next_s.st = H_RUN;
          end
        end
      H_GAP:
      begin
        next_s.cnt = s.cnt + 16'h1;
        if (s.cnt == 16'(GAP_CYC - 1))
        begin
          next_s.rd_stb = 1'b1;
          next_s.addr = ADR_RESULT_REG_0;
          next_s.st = H_RWAIT;
        end
      end
      default: next_s.st = H_IDLE;
    endcase
    if (start)
    begin
      next_s.st = H_WR;
      next_s.step = '0;
    end

    next_s.ev_sts = (s.ev_sts & ~clr) | ev;
    next_s.irq = |(next_s.ev_sts & next_s.ev_en);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign lnk.wr_stb = s.wr_stb;
  assign lnk.rd_stb = s.rd_stb;
  assign lnk.addr   = s.addr;
  assign lnk.wdata  = s.ldata;
  assign awready    = s.awready;
  assign wready     = s.wready;
  assign bresp      = s.bresp;
  assign bvalid     = s.bvalid;
  assign arready    = s.arready;
  assign rdata      = s.rdata;
  assign rresp      = s.rresp;
  assign rvalid     = s.rvalid;
  assign irq        = s.irq;
endmodule

// ### adc_group_init_fifo_read_monitor.sv
`timescale 1ns/10ps
module adc_group_init_fifo_read_monitor
  import adc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               wr_stb,
  input wire logic               rd_stb,
  input wire adc_pkg::reg_addr_t addr,
  input wire adc_pkg::word_t     wdata,
  input wire adc_pkg::word_t     rdata,
  input wire logic               rvalid,
  input wire logic               srq,
  input wire logic               analog_on,
  input wire logic               buf_boost,
  input wire logic               sample_on,
  input wire logic               cal_busy
);
  logic [7:0] boost_cnt;
  logic       rcr_en;
  logic       res_rd;
  logic [7:0] since_pop;

  // Boost length, service request enable and result pop trackers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boost_cnt <= 8'h00;
      rcr_en    <= 1'b0;
      res_rd    <= 1'b0;
      since_pop <= 8'hFF;
    end
    else
    begin
      boost_cnt <= buf_boost ? boost_cnt + 8'h01 : 8'h00;
      if (wr_stb && addr == ADR_RESULT_CONTROL_0)
        rcr_en <= wdata[SRQ_EN_BIT];
      if (rd_stb)
        res_rd <= (addr == ADR_RESULT_REG_0);
      if (rvalid && res_rd && rdata[RES_VALID_BIT])
        since_pop <= 8'h00;
      else if (since_pop != 8'hFF)
        since_pop <= since_pop + 8'h01;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  analog_up_a: assert property (
    wr_stb && addr == ADR_GROUP_ARBITRATION_CONFIG && wdata[1:0] == 2'b11
    |-> ##[1:2] analog_on)
    else $error("analog block not powered");
  cal_start_a: assert property (
    wr_stb && addr == ADR_GLOBAL_CONFIG && wdata[CAL_START_BIT]
    && analog_on && !cal_busy && !sample_on |-> ##[1:2] cal_busy)
    else $error("calibration not started");
  cal_conv_a: assert property (cal_busy |-> !sample_on)
    else $error("sampling during calibration");
  boost_len_a: assert property (
    $fell(buf_boost) |-> boost_cnt inside {8'h08, 8'h10, 8'h20})
    else $error("bad precharge length");
  boost_in_a: assert property (buf_boost |-> sample_on)
    else $error("boost outside sampling");
  read_lat_a: assert property (
    rd_stb |-> (!rvalid)[*5] ##[1:2] rvalid)
    else $error("read latency wrong");
  rv_pulse_a: assert property (rvalid |=> !rvalid)
    else $error("read answer too long");
  fifo_upd_a: assert property (
    rvalid && res_rd && rdata[RES_VALID_BIT] |-> since_pop >= 8'(UPD_CYC))
    else $error("result popped too soon");
  srq_en_a: assert property (srq |-> rcr_en)
    else $error("service request not enabled");
endmodule

// ### adc_group_init_fifo_read_tb_top.sv
`timescale 1ns/10ps
module adc_group_init_fifo_read_tb_top;
  import adc_pkg::*;
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  axi_addr_t        awaddr = 8'h00;
  axi_addr_t        araddr = 8'h00;
  word_t            wdata = 32'h0000_0000;
  logic             awvalid = 1'b0;
  logic             wvalid = 1'b0;
  logic             bready = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready = 1'b0;
  logic [RES_W-1:0] analog_data = 12'h000;
  logic             awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]       bresp, rresp;
  word_t            rdata;
  logic             analog_on, buf_boost, sample_on, cal_busy;
  logic [CH_W-1:0]  conv_channel;
  int               errors = 0;
  int               total_checks = 0;
  int               gap = 0;
  int               min_gap = 1000;
  int               res_reads = 0;
  logic             srq_seen = 1'b0;
  logic             srq_first = 1'b0;
  adc_link lnk ();

  adc_group #(.CAL_CYC(20), .CONV_CLKS(2)) i_adc_group (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk),
    .analog_data(analog_data), .analog_on(analog_on),
    .buf_boost(buf_boost), .sample_on(sample_on),
    .conv_channel(conv_channel), .cal_busy(cal_busy));
  adc_host i_adc_host (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  adc_group_init_fifo_read_monitor i_adc_group_init_fifo_read_monitor (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wr_stb(lnk.wr_stb),
    .rd_stb(lnk.rd_stb), .addr(lnk.addr), .wdata(lnk.wdata),
    .rdata(lnk.rdata), .rvalid(lnk.rvalid), .srq(lnk.srq),
    .analog_on(analog_on), .buf_boost(buf_boost),
    .sample_on(sample_on), .cal_busy(cal_busy));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) analog_data <= analog_data + 12'h001;

  // Spacing of result reads and service request before first read
  always @(posedge ref_clk)
  begin
    gap <= gap + 1;
    if (lnk.srq === 1'b1)
      srq_seen <= 1'b1;
    if (lnk.rd_stb === 1'b1 && lnk.addr === ADR_RESULT_REG_0)
    begin
      gap <= 0;
      res_reads <= res_reads + 1;
      if (res_reads == 0)
        srq_first <= srq_seen;
      if (res_reads > 0 && gap < min_gap)
        min_gap <= gap;
    end
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic axi_wr(input axi_addr_t a, input word_t d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(bresp === (a == 8'h0C ? RESP_SLVERR : RESP_OKAY), "bad bresp");
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input axi_addr_t a, output word_t d);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    check(rresp === (a == 8'h0C ? RESP_SLVERR : RESP_OKAY), "bad rresp");
    rready <= 1'b0;
  endtask

  task automatic t_reset;
    word_t d;
    axi_rd(AXI_STATUS, d);
    check(d === 32'h0000_0000, "status not idle");
    axi_rd(AXI_IRQ_ENABLE, d);
    check(d === 32'h0000_0000, "enable not clear");
    axi_rd(8'h0C, d);
    check(d === 32'h0000_0000, "unmapped read not zero");
    axi_wr(8'h0C, 32'h0000_0000);
  endtask

  task automatic t_init;
    word_t d;
    int    n;
    axi_wr(AXI_IRQ_ENABLE, 32'h0000_0001);
    axi_wr(AXI_CTRL, 32'h0000_0001);
    while (analog_on !== 1'b1) @(posedge ref_clk);
    n = 0;
    while (cal_busy !== 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(n >= WAKEUP_CYC, "wakeup wait short");
    while (irq !== 1'b1) @(posedge ref_clk);
    check(cal_busy === 1'b0, "calibration still busy");
    axi_rd(AXI_STATUS, d);
    check(d[1] === 1'b1, "not converting");
    axi_rd(AXI_IRQ_STATUS, d);
    check(d[EV_INIT_DONE] === 1'b1, "init event missing");
    axi_wr(AXI_IRQ_CLEAR, 32'h0000_0001);
    axi_rd(AXI_IRQ_STATUS, d);
    check(d[EV_INIT_DONE] === 1'b0 && irq === 1'b0, "clear failed");
  endtask

  task automatic t_boost;
    int n;
    int div;
    int len;
    div = int'(INIT_ANALOG_CONFIG[DIV_LSB +: 2]) + 1;
    len = (int'(INIT_INPUT_CLASS[STC_W-1:0]) + STC_BASE) * div;
    while (buf_boost === 1'b1) @(posedge ref_clk);
    while (buf_boost !== 1'b1) @(posedge ref_clk);
    n = 0;
    while (buf_boost === 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(n == PRE_LONG, "precharge length");
    check(sample_on === 1'b1, "no direct phase");
    check(conv_channel === INIT_QUEUE_INPUT[CH_W-1:0], "bad channel");
    while (sample_on === 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(n > len - div && n <= len, "sample length");
  endtask

  task automatic t_result;
    word_t d;
    axi_wr(AXI_IRQ_ENABLE, 32'h0000_0004);
    axi_wr(AXI_CTRL, 32'h0000_0002);
    while (irq !== 1'b1) @(posedge ref_clk);
    axi_rd(AXI_RESULT, d);
    check(d[RES_VALID_BIT] === 1'b1, "result invalid");
    check(d[20:16] === 5'h00, "wrong channel");
    check(srq_first === 1'b1, "read before request");
    check(min_gap >= GAP_CYC && res_reads >= 2,
          "reads too close");
    axi_wr(AXI_IRQ_ENABLE, 32'h0000_0000);
    axi_rd(AXI_IRQ_STATUS, d);
    check(d[EV_DRAINED] === 1'b1 && irq === 1'b0, "mask failed");
  endtask

  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_init();
    t_boost();
    t_result();
    final_report();
  end

  initial
  begin
    #2000000;
    errors++;
    final_report();
  end
endmodule
